// *** design/strap_pkg.sv ***
// constants shared by the strap capture logic
package strap_pkg;
	// strap pin ordering on the pin vector
	localparam int STRAP_COUNT    = 6;
	localparam int IDX_SPI_MODE   = 0;
	localparam int IDX_INTEGRITY  = 1;
	localparam int IDX_BOOT_HOLD  = 2;
	localparam int IDX_PORT_SEL   = 3;
	localparam int IDX_PROBE_ONE  = 4;
	localparam int IDX_PROBE_TWO  = 5;
	// sampling delay after reset release
	localparam real SAMPLE_DELAY_NS = 1500.0;
	localparam real CLK_PERIOD_NS   = 4.0;
	localparam int  SAMPLE_CYCLES   = int'(SAMPLE_DELAY_NS / CLK_PERIOD_NS);
	localparam int  CNT_W           = 10;
	// decoded encodings
	localparam logic SPI_MODE_0_3   = 1'h0;
	localparam logic SPI_MODE_1_2   = 1'h1;
	localparam logic INTEG_CRC8     = 1'h0;
	localparam logic INTEG_CHKSUM8  = 1'h1;
	localparam logic BOOT_LOAD_MAIN = 1'h0;
	localparam logic BOOT_STAY      = 1'h1;
	localparam logic PORT_SPI_CMD   = 1'h0;
	localparam logic PORT_I2C_CMD   = 1'h1;
	localparam logic [5:0] STRAP_RESET = 6'h00;
	typedef enum logic [2:0]
	{
		ST_WAIT    = 3'h1,
		ST_SAMPLE  = 3'h2,
		ST_RELEASE = 3'h4
	} cap_state_t;
endpackage

// *** design/strap_sync.sv ***
// two-stage synchroniser for a vector of pin inputs
module strap_sync #(
	parameter int WIDTH = 6
) (
	input  wire logic             i_core_clk,
	input  wire logic             i_rst_b,
	input  wire logic [WIDTH-1:0] i_async,
	output logic      [WIDTH-1:0] o_sync
);
	logic [WIDTH-1:0] stage_one;
	logic [WIDTH-1:0] stage_two;
	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			stage_one <= '0;
			stage_two <= '0;
		end
		else
		begin
			stage_one <= i_async;
			stage_two <= stage_one;
		end
	end
	assign o_sync = stage_two;
endmodule

// *** design/reset_strap_sampler.sv ***
// strap capture after power-on reset, with decoded configuration outputs
// Overview of operation
// - spi mode strap 0 selects clock modes 0 or 3, 1 selects modes 1 or 2
// - captured spi mode applies to host spi as command or monitoring port
// - integrity strap 0 selects 8-bit crc, 1 selects 8-bit checksum
// - integrity strap only affects command port; monitor port uses flash setting
// - boot hold strap 0 loads main application, 1 stays in boot
// - strap pins are never driven while reset is held low
// - straps captured about 1.5 us after reset rises; board holds them steady
// - a strap pin may be driven as debug output only after capture
// - weak pulldown means open strap reads 0; 1 needs strong pullup
// - port select 0 makes spi command port, 1 makes i2c; other monitors
// - reset rising edge starts self configuration including strap capture
module reset_strap_sampler #(
	parameter int SAMPLE_CNT = strap_pkg::SAMPLE_CYCLES
) (
	input  wire logic                          i_core_clk,
	input  wire logic                          i_rst_b,
	input  wire logic [strap_pkg::STRAP_COUNT-1:0] i_strap_pin,
	input  wire logic [strap_pkg::STRAP_COUNT-1:0] i_debug_data,
	input  wire logic                          i_debug_en,
	input  wire logic                          i_flash_integrity,
	output logic      [strap_pkg::STRAP_COUNT-1:0] o_strap_pin,
	output logic      [strap_pkg::STRAP_COUNT-1:0] o_strap_pin_oe,
	output logic                               o_captured,
	output logic                               o_spi_mode_1_2,
	output logic                               o_cmd_integrity,
	output logic                               o_mon_integrity,
	output logic                               o_boot_stay,
	output logic                               o_cmd_port_i2c,
	output logic                               o_mon_port_i2c,
	output logic                               o_spi_is_cmd
);
	import strap_pkg::*;

	// true when one bit of a strap vector holds the given code
	function automatic logic strap_is(
		input logic [STRAP_COUNT-1:0] bits,
		input int                     idx,
		input logic                   code
	);
		strap_is = (bits[idx] == code);
	endfunction

	logic [STRAP_COUNT-1:0] pin_sync;
	cap_state_t             state;
	cap_state_t             next_state;
	logic [CNT_W-1:0]       count;
	logic [CNT_W-1:0]       next_count;
	logic [STRAP_COUNT-1:0] straps;
	logic [STRAP_COUNT-1:0] next_straps;
	logic                   captured;
	logic                   next_captured;
	logic [STRAP_COUNT-1:0] pin_out;
	logic [STRAP_COUNT-1:0] next_pin_out;
	logic [STRAP_COUNT-1:0] pin_oe;
	logic [STRAP_COUNT-1:0] next_pin_oe;
	logic                   mon_integ;
	logic                   next_mon_integ;
	logic                   spi_mode_1_2;
	logic                   next_spi_mode_1_2;
	logic                   cmd_integ;
	logic                   next_cmd_integ;
	logic                   boot_stay;
	logic                   next_boot_stay;
	logic                   cmd_port_i2c;
	logic                   next_cmd_port_i2c;
	logic                   mon_port_i2c;
	logic                   next_mon_port_i2c;
	logic                   spi_is_cmd;
	logic                   next_spi_is_cmd;

	// straps are pin inputs; weak pulldown reads 0 when open
	strap_sync #(
		.WIDTH (STRAP_COUNT)
	) u_sync (
		.i_core_clk (i_core_clk),
		.i_rst_b    (i_rst_b),
		.i_async    (i_strap_pin),
		.o_sync     (pin_sync)
	);

	// sequencer starts on reset release
	always_comb
	begin
		next_state    = state;
		next_count    = count;
		next_straps   = straps;
		next_captured = captured;
		case (state)
			ST_WAIT:
			begin
				if (count >= CNT_W'(SAMPLE_CNT - 1))
					next_state = ST_SAMPLE;
				else
					next_count = count + CNT_W'(1);
			end
			ST_SAMPLE:
			begin
				next_straps   = pin_sync;
				next_captured = 1'h1;
				next_state    = ST_RELEASE;
			end
			ST_RELEASE:
			begin
				next_state = ST_RELEASE; // values frozen until reset
			end
			default:
			begin
				next_state = ST_WAIT;
			end
		endcase
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			state    <= ST_WAIT;
			count    <= '0;
			straps   <= STRAP_RESET;
			captured <= 1'h0;
		end
		else
		begin
			state    <= next_state;
			count    <= next_count;
			straps   <= next_straps;
			captured <= next_captured;
		end
	end

	// decoded configuration loads at the same edge as the raw straps, then holds
	always_comb
	begin
		next_spi_mode_1_2 = spi_mode_1_2;
		next_cmd_integ    = cmd_integ;
		next_boot_stay    = boot_stay;
		next_cmd_port_i2c = cmd_port_i2c;
		next_mon_port_i2c = mon_port_i2c;
		next_spi_is_cmd   = spi_is_cmd;
		if (state == ST_SAMPLE)
		begin
			next_spi_mode_1_2 = strap_is(pin_sync, IDX_SPI_MODE, SPI_MODE_1_2);
			next_cmd_integ    = strap_is(pin_sync, IDX_INTEGRITY, INTEG_CHKSUM8);
			next_boot_stay    = strap_is(pin_sync, IDX_BOOT_HOLD, BOOT_STAY);
			next_cmd_port_i2c = strap_is(pin_sync, IDX_PORT_SEL, PORT_I2C_CMD);
			next_mon_port_i2c = strap_is(pin_sync, IDX_PORT_SEL, PORT_SPI_CMD);
			next_spi_is_cmd   = strap_is(pin_sync, IDX_PORT_SEL, PORT_SPI_CMD);
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			spi_mode_1_2 <= 1'h0;
			cmd_integ    <= 1'h0;
			boot_stay    <= 1'h0;
			cmd_port_i2c <= 1'h0;
			mon_port_i2c <= 1'h0;
			spi_is_cmd   <= 1'h0;
		end
		else
		begin
			spi_mode_1_2 <= next_spi_mode_1_2;
			cmd_integ    <= next_cmd_integ;
			boot_stay    <= next_boot_stay;
			cmd_port_i2c <= next_cmd_port_i2c;
			mon_port_i2c <= next_mon_port_i2c;
			spi_is_cmd   <= next_spi_is_cmd;
		end
	end

	// pin drivers: tristate until capture, then optional debug drive
	always_comb
	begin
		next_pin_out = '0;
		next_pin_oe  = '0;
		if (captured && i_debug_en)
		begin
			next_pin_out = i_debug_data;
			next_pin_oe  = {STRAP_COUNT{1'h1}};
		end
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			pin_out <= '0;
			pin_oe  <= '0;
		end
		else
		begin
			pin_out <= next_pin_out;
			pin_oe  <= next_pin_oe;
		end
	end

	// monitor port integrity follows the flash setting, never the strap
	always_comb
	begin
		next_mon_integ = i_flash_integrity;
	end

	always_ff @(posedge i_core_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			mon_integ <= INTEG_CRC8;
		end
		else
		begin
			mon_integ <= next_mon_integ;
		end
	end

	assign o_strap_pin     = pin_out;
	assign o_strap_pin_oe  = pin_oe;
	assign o_captured      = captured;
	assign o_spi_mode_1_2  = spi_mode_1_2;
	assign o_cmd_integrity = cmd_integ;
	assign o_mon_integrity = mon_integ;
	assign o_boot_stay     = boot_stay;
	assign o_cmd_port_i2c  = cmd_port_i2c;
	assign o_mon_port_i2c  = mon_port_i2c;
	assign o_spi_is_cmd    = spi_is_cmd;
endmodule

// *** sim/board_straps.sv ***
// board strap resistors seen on the pins
module board_straps (
	input  wire logic [5:0] i_pull,
	input  wire logic [5:0] i_drv,
	input  wire logic [5:0] i_oe,
	output logic      [5:0] o_pin
);
	timeunit 1ns;
	timeprecision 1ps;
	// probe pins are only ever pulled low; an undriven pin settles to its pull
	assign o_pin = i_oe & i_drv | ~i_oe & i_pull & 6'h0F;
endmodule

// *** sim/reset_strap_sampler_assertions.sv ***
// port checks for the strap sampler
module strap_chk #(
	parameter int SAMPLE_CNT = 4
) (
	input  wire logic       i_core_clk,
	input  wire logic       i_rst_b,
	input  wire logic       i_debug_en,
	input  wire logic       i_flash_integrity,
	input  wire logic       o_captured,
	input  wire logic       o_spi_mode_1_2,
	input  wire logic       o_cmd_integrity,
	input  wire logic       o_mon_integrity,
	input  wire logic       o_boot_stay,
	input  wire logic       o_cmd_port_i2c,
	input  wire logic       o_mon_port_i2c,
	input  wire logic       o_spi_is_cmd,
	input  wire logic [5:0] i_strap_pin,
	input  wire logic [5:0] i_debug_data,
	input  wire logic [5:0] o_strap_pin,
	input  wire logic [5:0] o_strap_pin_oe
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [9:0] cnt;
	logic [9:0] next_cnt;
	wire logic [3:0] dec = {o_cmd_port_i2c, o_boot_stay, o_cmd_integrity, o_spi_mode_1_2};
	assign next_cnt = cnt + 10'(cnt != 10'h3FF);
	always_ff @(posedge i_core_clk or negedge i_rst_b)
		if (!i_rst_b)
			cnt <= 10'h000;
		else
			cnt <= next_cnt;
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rst_b);
	a_cap_time: assert property (o_captured == (cnt > SAMPLE_CNT)) else $error("time");
	a_oe_quiet: assert property (!o_captured |-> !o_strap_pin_oe) else $error("oe");
	a_cap_hold: assert property (o_captured |=> o_captured && $stable(dec)) else $error("hold");
	a_dbg_drive: assert property (o_captured && i_debug_en |=> &o_strap_pin_oe
		&& o_strap_pin == $past(i_debug_data)) else $error("debug drive");
	a_mon_flash: assert property ($past(i_rst_b) |->
		o_mon_integrity == $past(i_flash_integrity)) else $error("monitor integrity");
	a_mon_port: assert property (o_captured |-> o_mon_port_i2c != o_cmd_port_i2c)
		else $error("monitor port");
	a_spi_cmd: assert property (o_captured |-> o_spi_is_cmd != o_cmd_port_i2c)
		else $error("spi port");
	a_strap_decode: assert property ($rose(o_captured) && $past(i_strap_pin, 6) == i_strap_pin
		|-> dec == i_strap_pin[3:0]) else $error("decode");
	c_capture: cover property ($rose(o_captured));
	c_debug: cover property (o_captured && i_debug_en);
	c_boot_stay: cover property (o_captured && o_boot_stay);
endmodule
bind reset_strap_sampler strap_chk #(.SAMPLE_CNT(SAMPLE_CNT)) strap_chk_inst (
	.i_core_clk        (i_core_clk),
	.i_rst_b           (i_rst_b),
	.i_debug_en        (i_debug_en),
	.i_flash_integrity (i_flash_integrity),
	.o_captured        (o_captured),
	.o_spi_mode_1_2    (o_spi_mode_1_2),
	.o_cmd_integrity   (o_cmd_integrity),
	.o_mon_integrity   (o_mon_integrity),
	.o_boot_stay       (o_boot_stay),
	.o_cmd_port_i2c    (o_cmd_port_i2c),
	.o_mon_port_i2c    (o_mon_port_i2c),
	.o_spi_is_cmd      (o_spi_is_cmd),
	.i_strap_pin       (i_strap_pin),
	.i_debug_data      (i_debug_data),
	.o_strap_pin       (o_strap_pin),
	.o_strap_pin_oe    (o_strap_pin_oe)
);

// *** sim/reset_strap_sampler_tb.sv ***
// self-checking bench for the strap sampler
module reset_strap_sampler_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import strap_pkg::*;
	localparam int N = 4;
	logic i_core_clk = 0, i_rst_b = 0, i_debug_en = 0, i_flash_integrity = 0;
	logic [5:0] pull = 6'h00, i_debug_data = 6'h00;
	wire logic [5:0] i_strap_pin, o_strap_pin, o_strap_pin_oe;
	wire logic o_captured, o_spi_mode_1_2, o_cmd_integrity, o_mon_integrity, o_boot_stay;
	wire logic o_cmd_port_i2c, o_mon_port_i2c, o_spi_is_cmd;
	wire logic [5:0] dec = {o_spi_is_cmd, o_mon_port_i2c, o_cmd_port_i2c, o_boot_stay,
		o_cmd_integrity, o_spi_mode_1_2};
	int n_fail = 0, comparisons = 0;
	always #2 i_core_clk = ~i_core_clk;
	board_straps board_straps_inst (.i_pull(pull), .i_drv(o_strap_pin), .i_oe(o_strap_pin_oe),
		.o_pin(i_strap_pin));
	reset_strap_sampler #(.SAMPLE_CNT(N)) reset_strap_sampler_inst (
		.i_core_clk        (i_core_clk),
		.i_rst_b           (i_rst_b),
		.i_strap_pin       (i_strap_pin),
		.i_debug_data      (i_debug_data),
		.i_debug_en        (i_debug_en),
		.i_flash_integrity (i_flash_integrity),
		.o_strap_pin       (o_strap_pin),
		.o_strap_pin_oe    (o_strap_pin_oe),
		.o_captured        (o_captured),
		.o_spi_mode_1_2    (o_spi_mode_1_2),
		.o_cmd_integrity   (o_cmd_integrity),
		.o_mon_integrity   (o_mon_integrity),
		.o_boot_stay       (o_boot_stay),
		.o_cmd_port_i2c    (o_cmd_port_i2c),
		.o_mon_port_i2c    (o_mon_port_i2c),
		.o_spi_is_cmd      (o_spi_is_cmd)
	);
	task automatic chk(input logic [11:0] got, input logic [11:0] exp);
		comparisons++;
		if (got !== exp)
		begin
			n_fail++;
			$display("MISMATCH %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic final_report;
		if (n_fail == 0 && comparisons > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	// power-on with strap pattern p; debug drive is requested until just before the final oe release check
	task automatic boot(input logic [3:0] p);
		int k;
		logic [5:0] e;
		e = {~p[3], ~p[3], p[3] ? PORT_I2C_CMD : PORT_SPI_CMD, p[2] ? BOOT_STAY : BOOT_LOAD_MAIN,
			p[1] ? INTEG_CHKSUM8 : INTEG_CRC8, p[0] ? SPI_MODE_1_2 : SPI_MODE_0_3};
		i_rst_b = 0;
		pull = {2'h0, p};
		i_debug_data = {p, 2'h2};
		i_debug_en = 1;
		repeat (20) @(negedge i_core_clk);
		chk({o_strap_pin_oe, i_strap_pin}, {6'h00, pull});
		i_rst_b = 1;
		k = 0;
		while (o_captured !== 1'b1 && k < 100)
		begin
			@(negedge i_core_clk);
			k++;
		end
		if (k == 100)
		begin
			n_fail++;
			final_report();
		end
		chk(k, N + 1);
		chk(dec, e);
		@(negedge i_core_clk);
		chk({o_strap_pin_oe, o_strap_pin}, {6'h3F, i_debug_data});
		i_flash_integrity = ~i_flash_integrity;
		repeat (4) @(negedge i_core_clk);
		chk(o_mon_integrity, i_flash_integrity);
		chk(dec, e);
		i_debug_en = 0;
		@(negedge i_core_clk);
		chk(o_strap_pin_oe, 6'h00);
	endtask
	initial
	begin
		for (int p = 0; p < 16; p++)
			boot(4'(p));
		final_report();
	end
endmodule
